// ### logic/isc_defs.vh
// Purpose: Constants for the interrupt and standby controller.
// Assumes: Avalon-MM slave with 32-bit data, one aligned word per register.
// Notes:   Offsets are byte addresses.
`ifndef ISC_DEFS_VH
`define ISC_DEFS_VH

`define ISC_ADDR_W        6
`define ISC_OFS_FLAG_LO   6'h00
`define ISC_OFS_FLAG_HI   6'h04
`define ISC_OFS_EN_LO     6'h08
`define ISC_OFS_EN_HI     6'h0c
`define ISC_OFS_PRIO      6'h10
`define ISC_OFS_EDGE      6'h14
`define ISC_OFS_STATE     6'h18

`define ISC_NSRC          37
`define ISC_NGRP          5
`define ISC_PORT_LSB      0
`define ISC_PORT_N        8
`define ISC_CT_LSB        8
`define ISC_CT_N          4
`define ISC_SW_LSB        12
`define ISC_SW_N          3
`define ISC_PT_LSB        15
`define ISC_PT_N          16
`define ISC_SER_LSB       31
`define ISC_SER_N         6

`define ISC_FLAG_RST      37'h0000000000
`define ISC_EN_RST        37'h0000000000
`define ISC_PRIO_RST      10'h000
`define ISC_EDGE_RST      8'h00

`define ISC_CLK_HZ        64'd100000000
`define ISC_LOSC_PERIODS  64'd128
`define ISC_LOSC_HZ       64'd32768
`define ISC_HOSC_PERIODS  64'd512
`define ISC_HOSC_HZ       64'd4000000
// Stabilisation waits in clk cycles for the periods and oscillator rates above.
`define ISC_STAB_LOW_CYC  20'd390625
`define ISC_STAB_HIGH_CYC 20'd12800
`define ISC_STAB_W        20

`endif

// ### logic/isc_interrupt_standby.v
// Purpose: Interrupt gathering, group priority and halt/sleep control.
// Assumes: Event inputs other than the port pins are one-cycle pulses on clk.
// Notes:   Registers are reached over Avalon-MM with waitrequest.
// Function
// - Accept 37 sources in five groups.
// - Each source has own flag and enable.
// - Each group has writable three-level priority.
// - Event sets flag regardless of enable.
// - Enable one permits, zero blocks request.
// - Request needs flag, enable, priority above mask.
// - Halt stops processor, peripherals keep running.
// - Halt ends on reset or enabled request.
// - Sleep stops processor and all peripherals.
// - Only reset or port interrupt ends sleep.
// - Stabilisation wait chosen by oscillator at entry.
// - Wake from sleep via port interrupt routine.
// - Writing one clears flag, zero unchanged.
// - Flag left set repeats the interrupt.
// - Reset clears every pending flag.
// - Reset clears enables; enables read back.
//
// The register offsets and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/10ps
`include "isc_defs.vh"

module isc_interrupt_standby #(
   parameter [`ISC_STAB_W-1:0] STAB_LOW_CYC  = `ISC_STAB_LOW_CYC,
   parameter [`ISC_STAB_W-1:0] STAB_HIGH_CYC = `ISC_STAB_HIGH_CYC
) (
   input  wire                   clk,
   input  wire                   nrst,
   input  wire                   clkEn,
   input  wire [`ISC_ADDR_W-1:0] address,
   input  wire                   read,
   input  wire                   write,
   input  wire [31:0]            writedata,
   output wire [31:0]            readdata,
   output wire                   waitrequest,
   input  wire [7:0]             inputPortPins,
   input  wire [3:0]             clockTimerEvt,
   input  wire [2:0]             stopwatchEvt,
   input  wire [15:0]            progTimerEvt,
   input  wire [5:0]             serialEvt,
   input  wire                   cpuMaskBitLow,
   input  wire                   cpuMaskBitHigh,
   input  wire                   haltInstruction,
   input  wire                   sleepInstruction,
   input  wire                   highOscRunning,
   output wire                   irq,
   output wire                   cpuIntReq,
   output wire [1:0]             cpuIntLevel,
   output wire                   cpuRun,
   output wire                   periphClkEn,
   output wire                   wakePortVector,
   output wire [3:0]             standbyState
);

   localparam [3:0] ST_RUN   = 4'h1;
   localparam [3:0] ST_HALT  = 4'h2;
   localparam [3:0] ST_SLEEP = 4'h4;
   localparam [3:0] ST_STAB  = 4'h8;
   localparam [`ISC_STAB_W-1:0] STAB_ONE = {{(`ISC_STAB_W-1){1'b0}}, 1'b1};

   reg  [`ISC_NSRC-1:0]    flags_r;
   reg  [`ISC_NSRC-1:0]    flags_nxt;
   reg  [`ISC_NSRC-1:0]    enables_r;
   reg  [2*`ISC_NGRP-1:0]  prio_r;
   reg  [7:0]              edgeFall_r;
   reg  [7:0]              pinSync1_r;
   reg  [7:0]              pinSync2_r;
   reg  [7:0]              pinPrev_r;
   reg  [2:0]              pinPrimed_r;
   reg  [31:0]             readdata_r;
   reg  [31:0]             readdata_nxt;
   reg                     waitReq_r;
   reg                     irq_r;
   reg                     cpuIntReq_r;
   reg  [1:0]              cpuIntLevel_r;
   reg                     cpuRun_r;
   reg                     periphClkEn_r;
   reg                     wakePort_r;
   reg  [3:0]              state_r;
   reg  [3:0]              state_nxt;
   reg  [`ISC_STAB_W-1:0]  stabCnt_r;
   reg  [`ISC_STAB_W-1:0]  stabCnt_nxt;
   reg                     anyReq;
   reg  [1:0]              bestLevel;
   reg  [`ISC_NSRC-1:0]    clearMask;
   integer                 g;

   wire [1:0]              cpuMask;
   wire [7:0]              pinRise;
   wire [7:0]              pinFall;
   wire [7:0]              portEvt;
   wire                    periphRun;
   wire [`ISC_NSRC-1:0]    srcEvt;
   wire [`ISC_NSRC-1:0]    active;
   wire                    busWr;
   wire                    wrFlagLo;
   wire                    wrFlagHi;
   wire                    wrEnLo;
   wire                    wrEnHi;
   wire                    wrPrio;
   wire                    wrEdge;

   assign cpuMask = {cpuMaskBitHigh, cpuMaskBitLow};
   // The edge detector stays quiet until the synchroniser holds real pin samples.
   assign pinRise = pinSync2_r & ~pinPrev_r & {8{pinPrimed_r[2]}};
   assign pinFall = ~pinSync2_r & pinPrev_r & {8{pinPrimed_r[2]}};
   // Each pin triggers on the edge that its select bit names.
   assign portEvt = (pinFall & edgeFall_r) | (pinRise & ~edgeFall_r);
   // Peripheral events are suppressed while their clocks are stopped.
   assign periphRun = (state_r == ST_RUN) || (state_r == ST_HALT);
   assign srcEvt = {serialEvt & {`ISC_SER_N{periphRun}},
                    progTimerEvt & {`ISC_PT_N{periphRun}},
                    stopwatchEvt & {`ISC_SW_N{periphRun}},
                    clockTimerEvt & {`ISC_CT_N{periphRun}},
                    portEvt};
   assign active = flags_r & enables_r;
   assign busWr = write && !waitReq_r;

   // Returns the group number of a source index.
   function [2:0] groupOf;
      input integer idx;
      begin
         if (idx < `ISC_CT_LSB)
            groupOf = 3'h0;
         else if (idx < `ISC_SW_LSB)
            groupOf = 3'h1;
         else if (idx < `ISC_PT_LSB)
            groupOf = 3'h2;
         else if (idx < `ISC_SER_LSB)
            groupOf = 3'h3;
         else
            groupOf = 3'h4;
      end
   endfunction

   // Returns the two-bit priority field of a group.
   function [1:0] prioOf;
      input [2*`ISC_NGRP-1:0] pr;
      input [2:0]             grp;
      begin
         prioOf = pr[2*grp +: 2];
      end
   endfunction

   // Returns one when a completed write targets the given offset.
   function wrHit;
      input [`ISC_ADDR_W-1:0] adr;
      input                   wr;
      input [`ISC_ADDR_W-1:0] ofs;
      begin
         wrHit = wr && (adr == ofs);
      end
   endfunction

   assign wrFlagLo = wrHit(address, busWr, `ISC_OFS_FLAG_LO);
   assign wrFlagHi = wrHit(address, busWr, `ISC_OFS_FLAG_HI);
   assign wrEnLo   = wrHit(address, busWr, `ISC_OFS_EN_LO);
   assign wrEnHi   = wrHit(address, busWr, `ISC_OFS_EN_HI);
   assign wrPrio   = wrHit(address, busWr, `ISC_OFS_PRIO);
   assign wrEdge   = wrHit(address, busWr, `ISC_OFS_EDGE);

   always @* begin
      anyReq = 1'b0;
      bestLevel = 2'h0;
      for (g = 0; g < `ISC_NSRC; g = g + 1) begin
         if (active[g] && (prioOf(prio_r, groupOf(g)) > cpuMask)) begin
            anyReq = 1'b1;
            if (prioOf(prio_r, groupOf(g)) > bestLevel)
               bestLevel = prioOf(prio_r, groupOf(g));
         end
      end
   end

   always @* begin
      clearMask = {`ISC_NSRC{1'b0}};
      if (wrFlagLo)
         clearMask[31:0] = writedata;
      if (wrFlagHi)
         clearMask[`ISC_NSRC-1:32] = writedata[`ISC_NSRC-33:0];
      // A new event in the clearing cycle keeps its flag set.
      flags_nxt = (flags_r & ~clearMask) | srcEvt;
   end

   always @* begin
      // Read data is captured in the wait cycle so that it stands when waitrequest drops.
      readdata_nxt = readdata_r;
      if (read && waitReq_r) begin
         case (address)
            `ISC_OFS_FLAG_LO: readdata_nxt = flags_r[31:0];
            `ISC_OFS_FLAG_HI: readdata_nxt = {27'h0000000, flags_r[`ISC_NSRC-1:32]};
            `ISC_OFS_EN_LO:   readdata_nxt = enables_r[31:0];
            `ISC_OFS_EN_HI:   readdata_nxt = {27'h0000000, enables_r[`ISC_NSRC-1:32]};
            `ISC_OFS_PRIO:    readdata_nxt = {22'h000000, prio_r};
            `ISC_OFS_EDGE:    readdata_nxt = {24'h000000, edgeFall_r};
            `ISC_OFS_STATE:   readdata_nxt = {26'h0000000, anyReq, |active, state_r};
            default:          readdata_nxt = 32'h00000000;
         endcase
      end
   end

   always @* begin
      state_nxt = state_r;
      stabCnt_nxt = stabCnt_r;
      case (state_r)
         ST_RUN: begin
            if (sleepInstruction) begin
               state_nxt = ST_SLEEP;
               stabCnt_nxt = highOscRunning ? STAB_HIGH_CYC : STAB_LOW_CYC;
            end else if (haltInstruction) begin
               state_nxt = ST_HALT;
            end
         end
         ST_HALT: begin
            if (|active)
               state_nxt = ST_RUN;
         end
         ST_SLEEP: begin
            if (|(portEvt & enables_r[`ISC_PORT_N-1:0]))
               state_nxt = ST_STAB;
         end
         ST_STAB: begin
            if (stabCnt_r <= STAB_ONE)
               state_nxt = ST_RUN;
            else
               stabCnt_nxt = stabCnt_r - STAB_ONE;
         end
         default: begin
            state_nxt = ST_RUN;
         end
      endcase
   end

   // Two flip-flops take the pins into the clock domain before any logic reads them.
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pinSync1_r  <= 8'h00;
         pinSync2_r  <= 8'h00;
         pinPrev_r   <= 8'h00;
         pinPrimed_r <= 3'h0;
      end else if (clkEn) begin
         pinSync1_r  <= inputPortPins;
         pinSync2_r  <= pinSync1_r;
         pinPrev_r   <= pinSync2_r;
         pinPrimed_r <= {pinPrimed_r[1:0], 1'b1};
      end
   end

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         flags_r       <= `ISC_FLAG_RST;
         enables_r     <= `ISC_EN_RST;
         prio_r        <= `ISC_PRIO_RST;
         edgeFall_r    <= `ISC_EDGE_RST;
         readdata_r    <= 32'h00000000;
         waitReq_r     <= 1'b1;
         irq_r         <= 1'b0;
         cpuIntReq_r   <= 1'b0;
         cpuIntLevel_r <= 2'h0;
         cpuRun_r      <= 1'b1;
         periphClkEn_r <= 1'b1;
         wakePort_r    <= 1'b0;
         state_r       <= ST_RUN;
         stabCnt_r     <= {`ISC_STAB_W{1'b0}};
      end else if (clkEn) begin
         flags_r       <= flags_nxt;
         readdata_r    <= readdata_nxt;
         // Waitrequest drops for one cycle to complete each request.
         waitReq_r     <= !((read || write) && waitReq_r);
         if (wrEnLo)
            enables_r[31:0] <= writedata;
         if (wrEnHi)
            enables_r[`ISC_NSRC-1:32] <= writedata[`ISC_NSRC-33:0];
         if (wrPrio)
            prio_r <= writedata[2*`ISC_NGRP-1:0];
         if (wrEdge)
            edgeFall_r <= writedata[7:0];
         irq_r         <= |active;
         cpuIntReq_r   <= anyReq;
         cpuIntLevel_r <= bestLevel;
         state_r       <= state_nxt;
         stabCnt_r     <= stabCnt_nxt;
         cpuRun_r      <= (state_nxt == ST_RUN);
         periphClkEn_r <= (state_nxt == ST_RUN) || (state_nxt == ST_HALT);
         wakePort_r    <= (state_r == ST_STAB) && (state_nxt == ST_RUN);
      end
   end

   assign readdata       = readdata_r;
   assign waitrequest    = waitReq_r;
   assign irq            = irq_r;
   assign cpuIntReq      = cpuIntReq_r;
   assign cpuIntLevel    = cpuIntLevel_r;
   assign cpuRun         = cpuRun_r;
   assign periphClkEn    = periphClkEn_r;
   assign wakePortVector = wakePort_r;
   assign standbyState   = state_r;

endmodule // isc_interrupt_standby

// ### test/isc_chk.sv
// Purpose: Port checker for the interrupt and standby controller.
// Assumes: One clock domain, reset active low.
// Notes:   Attached to the design by bind.
`timescale 1ns/10ps
module isc_chk #(
   parameter int STAB_LOW_CYC  = 5,
   parameter int STAB_HIGH_CYC = 3
) (
   input wire logic       clk,
   input wire logic       nrst,
   input wire logic       sleepInstruction,
   input wire logic       cpuMaskBitLow,
   input wire logic       cpuMaskBitHigh,
   input wire logic       irq,
   input wire logic       cpuIntReq,
   input wire logic [1:0] cpuIntLevel,
   input wire logic       cpuRun,
   input wire logic       periphClkEn,
   input wire logic       wakePortVector,
   input wire logic [3:0] standbyState
);
   logic [19:0] stabCnt_r;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // Counts the cycles spent in the stabilisation wait.
   always @(posedge clk or negedge nrst) begin
      if (!nrst) stabCnt_r <= 20'h00000;
      else stabCnt_r <= (standbyState == 4'h8) ? stabCnt_r + 20'h00001 : 20'h00000;
   end
   AST_REQ_ABOVE: assert property (cpuIntReq |-> cpuIntLevel > {$past(cpuMaskBitHigh), $past(cpuMaskBitLow)})
      else $error("request level not above mask");
   AST_LVL_ZERO: assert property (!cpuIntReq |-> cpuIntLevel == 2'h0)
      else $error("level without request");
   AST_REQ_IRQ: assert property (cpuIntReq |-> irq)
      else $error("request without enabled flag");
   AST_HALT_RUN: assert property (standbyState == 4'h2 |-> !cpuRun && periphClkEn)
      else $error("halt outputs wrong");
   AST_SLEEP_STOP: assert property (standbyState == 4'h4 |-> !cpuRun && !periphClkEn)
      else $error("sleep outputs wrong");
   AST_SLEEP_GO: assert property (sleepInstruction && standbyState == 4'h1 |=> standbyState == 4'h4)
      else $error("sleep not entered");
   AST_SLEEP_EXIT: assert property (standbyState == 4'h4 |=> standbyState == 4'h4 || standbyState == 4'h8)
      else $error("sleep left without port wake");
   AST_HALT_END: assert property (standbyState == 4'h2 && irq |-> ##[0:1] standbyState == 4'h1)
      else $error("halt not left");
   AST_WAKE_VEC: assert property (wakePortVector |-> cpuRun && $past(standbyState) == 4'h8)
      else $error("wake vector outside wake");
   AST_STAB_LEN: assert property (stabCnt_r <= ((STAB_LOW_CYC > STAB_HIGH_CYC) ? STAB_LOW_CYC : STAB_HIGH_CYC))
      else $error("stabilisation wait too long");
endmodule // isc_chk
bind isc_interrupt_standby isc_chk #(.STAB_LOW_CYC(STAB_LOW_CYC), .STAB_HIGH_CYC(STAB_HIGH_CYC)) chk (.clk(clk),
   .nrst(nrst), .sleepInstruction(sleepInstruction), .cpuMaskBitLow(cpuMaskBitLow), .cpuMaskBitHigh(cpuMaskBitHigh),
   .irq(irq), .cpuIntReq(cpuIntReq), .cpuIntLevel(cpuIntLevel), .cpuRun(cpuRun), .periphClkEn(periphClkEn),
   .wakePortVector(wakePortVector), .standbyState(standbyState));

// ### test/isc_cpu_model.sv
// Purpose: Processor core model that holds the mask and takes requests.
// Assumes: Every running cycle is an opcode fetch.
// Notes:   Counts accepted requests.
`timescale 1ns/10ps
module isc_cpu_model (
   input wire logic         clk,
   input wire logic         nrst,
   input wire logic         cpuRun,
   input wire logic         cpuIntReq,
   input wire logic [1:0]   cpuIntLevel,
   input wire logic [1:0]   maskLvl,
   output logic             maskLow,
   output logic             maskHigh,
   output logic [15:0]      accCnt
);
   assign maskLow = maskLvl[0];
   assign maskHigh = maskLvl[1];
   // Takes a request only above the mask, sampled at each fetch.
   always @(posedge clk or negedge nrst) begin
      if (!nrst) accCnt <= 16'h0000;
      else if (cpuRun && cpuIntReq && cpuIntLevel > maskLvl) accCnt <= accCnt + 16'h0001;
   end
endmodule // isc_cpu_model

// ### test/tb.sv
// Purpose: Self-checking bench for the interrupt and standby controller.
// Assumes: Short stabilisation counts of 5 and 3 cycles.
// Notes:   Table rows cover every source group.
`timescale 1ns/10ps
`include "isc_defs.vh"
module tb;
   logic        clk = 1'b0, nrst = 1'b0, read = 1'b0, write = 1'b0, halt = 1'b0, sleep = 1'b0, hosc = 1'b0;
   logic [5:0]  address = 6'h00, fa, ea;
   logic [31:0] writedata = 32'h0, readdata, rd, b;
   logic [36:0] evt = 37'h0;
   logic [1:0]  maskLvl = 2'h0, cpuIntLevel;
   logic [3:0]  standbyState;
   logic        waitrequest, irq, cpuIntReq, cpuRun, periphClkEn, wakePortVector, maskLow, maskHigh;
   logic [15:0] accCnt, acc0;
   logic [14:0] r;
   logic [14:0] rows [10] = '{{6'd0, 2'd1, 2'd0, 3'b111, 2'd1}, {6'd7, 2'd3, 2'd2, 3'b111, 2'd3},
      {6'd8, 2'd2, 2'd2, 3'b110, 2'd0}, {6'd11, 2'd2, 2'd1, 3'b111, 2'd2}, {6'd12, 2'd3, 2'd3, 3'b110, 2'd0},
      {6'd14, 2'd1, 2'd0, 3'b000, 2'd0}, {6'd15, 2'd0, 2'd0, 3'b110, 2'd0}, {6'd30, 2'd3, 2'd0, 3'b111, 2'd3},
      {6'd31, 2'd2, 2'd1, 3'b111, 2'd2}, {6'd36, 2'd1, 2'd0, 3'b111, 2'd1}};
   int          errors = 0, n_tests = 0, cyc = 0, i, k, sl, sh;
   always #5 clk = ~clk;
   isc_interrupt_standby #(.STAB_LOW_CYC(20'd5), .STAB_HIGH_CYC(20'd3)) dut (.clk(clk), .nrst(nrst), .clkEn(1'b1),
      .address(address), .read(read), .write(write), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .inputPortPins(evt[7:0]), .clockTimerEvt(evt[11:8]), .stopwatchEvt(evt[14:12]),
      .progTimerEvt(evt[30:15]), .serialEvt(evt[36:31]), .cpuMaskBitLow(maskLow), .cpuMaskBitHigh(maskHigh),
      .haltInstruction(halt), .sleepInstruction(sleep), .highOscRunning(hosc), .irq(irq), .cpuIntReq(cpuIntReq),
      .cpuIntLevel(cpuIntLevel), .cpuRun(cpuRun), .periphClkEn(periphClkEn), .wakePortVector(wakePortVector),
      .standbyState(standbyState));
   isc_cpu_model cpu (.clk(clk), .nrst(nrst), .cpuRun(cpuRun), .cpuIntReq(cpuIntReq), .cpuIntLevel(cpuIntLevel),
      .maskLvl(maskLvl), .maskLow(maskLow), .maskHigh(maskHigh), .accCnt(accCnt));
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
      @(posedge clk);
      address <= a;
      writedata <= d;
      write <= wr;
      read <= !wr;
      @(posedge clk);
      while (waitrequest !== 1'b0) @(posedge clk);
      rd = readdata;
      write <= 1'b0;
      read <= 1'b0;
   endtask
   task pulse(input int s);
      @(posedge clk);
      evt[s] <= 1'b1;
      @(posedge clk);
      evt[s] <= 1'b0;
      repeat (5) @(posedge clk);
   endtask
   task sleepWake(input logic h, output int n);
      @(posedge clk);
      hosc <= h;
      sleep <= 1'b1;
      @(posedge clk);
      sleep <= 1'b0;
      @(posedge clk);
      chk("sleep state", standbyState, 4'h4);
      chk("sleep periph", periphClkEn, 0);
      pulse(20);
      chk("timer no wake", standbyState, 4'h4);
      evt[3] <= 1'b1;
      n = 0;
      for (k = 0; k < 100 && wakePortVector !== 1'b1; k++) begin
         @(posedge clk);
         evt[3] <= 1'b0;
         if (standbyState === 4'h8) n++;
      end
      chk("wake vector", wakePortVector, 1);
      chk("run after wake", cpuRun, 1);
      bus(1, `ISC_OFS_FLAG_LO, 32'h8);
   endtask
   task results;
      $display("tests %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc > 20000) begin
         errors++;
         results;
      end
   end
   initial begin
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      bus(0, `ISC_OFS_FLAG_LO, 0);
      chk("flag reset", rd, 0);
      bus(0, `ISC_OFS_PRIO, 0);
      chk("prio reset", rd, 0);
      bus(0, 6'h1c, 0);
      chk("unmapped", rd, 0);
      for (i = 0; i < 10; i++) begin
         r = rows[i];
         b = 32'h1 << r[13:9];
         fa = r[14] ? `ISC_OFS_FLAG_HI : `ISC_OFS_FLAG_LO;
         ea = r[14] ? `ISC_OFS_EN_HI : `ISC_OFS_EN_LO;
         bus(1, ea, r[4] ? b : 0);
         bus(1, `ISC_OFS_PRIO, {22'h0, {5{r[8:7]}}});
         maskLvl <= r[6:5];
         acc0 = accCnt;
         pulse(r[14:9]);
         chk("irq", irq, r[3]);
         chk("request", cpuIntReq, r[2]);
         chk("level", cpuIntLevel, r[1:0]);
         chk("taken", accCnt != acc0, r[2]);
         bus(0, ea, 0);
         chk("enable readback", rd, r[4] ? b : 0);
         bus(1, fa, 0);
         bus(0, fa, 0);
         chk("flag set", rd, b);
         bus(1, fa, b);
         bus(0, fa, 0);
         chk("flag cleared", rd, 0);
         bus(1, ea, 0);
      end
      bus(1, `ISC_OFS_EDGE, 32'h2);
      bus(0, `ISC_OFS_EDGE, 0);
      chk("edge readback", rd, 32'h2);
      evt[1] <= 1'b1;
      repeat (5) @(posedge clk);
      bus(0, `ISC_OFS_FLAG_LO, 0);
      chk("rise ignored", rd, 0);
      evt[1] <= 1'b0;
      repeat (5) @(posedge clk);
      bus(0, `ISC_OFS_FLAG_LO, 0);
      chk("fall flag", rd, 32'h2);
      bus(1, `ISC_OFS_FLAG_LO, 32'h2);
      bus(1, `ISC_OFS_EN_LO, 32'h8008);
      @(posedge clk);
      halt <= 1'b1;
      @(posedge clk);
      halt <= 1'b0;
      @(posedge clk);
      chk("halt state", standbyState, 4'h2);
      chk("halt cpu", cpuRun, 0);
      chk("halt periph", periphClkEn, 1);
      pulse(15);
      chk("halt left", standbyState, 4'h1);
      acc0 = accCnt;
      bus(0, `ISC_OFS_STATE, 0);
      chk("state word", rd, 32'h31);
      chk("repeat", accCnt != acc0, 1);
      @(posedge clk);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      bus(0, `ISC_OFS_EN_LO, 0);
      chk("enable mid reset", rd, 0);
      bus(0, `ISC_OFS_FLAG_LO, 0);
      chk("flag mid reset", rd, 0);
      bus(1, `ISC_OFS_EN_LO, 32'h100008);
      sleepWake(1'b1, sh);
      sleepWake(1'b0, sl);
      chk("wait by oscillator", sl > sh, 1);
      chk("wait high", sh, 3);
      chk("wait low", sl, 5);
      results;
   end
endmodule // tb
